// ===== core/rpd_map.svh
`ifndef RPD_MAP_SVH
`define RPD_MAP_SVH
`define RPD_REF_CLK_MHZ 50
`define RPD_PAIR_W      2
`define RPD_IDLE_PAIR   2'h0
`define RPD_DIV_W       4
`define RPD_DIV_LAST    4'h9
`define RPD_DIV_ZERO    4'h0
`endif

// ===== core/rpd_pkg.sv
package rpd_pkg;
    typedef enum logic [1:0] {
        RPD_TX_IDLE  = 2'h1,
        RPD_TX_FRAME = 2'h2
    } rpd_tx_state_t;
endpackage

// ===== core/rpd_data_port.sv
`timescale 1ns/100ps
`include "rpd_map.svh"
module rpd_data_port (
    input  wire logic        CLOCK_I,
    input  wire logic        SRST_I,
    input  wire logic        SPEED_100_I,
    output logic             RX_FRAME_DONE_O,
    output logic             RX_ERROR_SEEN_O,
    output logic             TX_FRAME_DONE_O,
    input  wire logic        REF_CLK_I,
    output logic             CRS_DV_O,
    output logic [1:0]       RXD_O,
    output logic             RX_ER_O,
    input  wire logic        TX_EN_I,
    input  wire logic [1:0]  TXD_I,
    input  wire logic        LINE_CARRIER_I,
    input  wire logic        LINE_RX_LOCK_I,
    input  wire logic [1:0]  LINE_RX_PAIR_I,
    input  wire logic        LINE_RX_CODE_ERR_I,
    output logic             LINE_TX_EN_O,
    output logic [1:0]       LINE_TX_PAIR_O,
    output logic             LINE_TX_STROBE_O
);
    // System clock domain: speed setting and frame event pulses.
    logic        speed_q;
    logic [2:0]  rx_tog_s;
    logic [2:0]  tx_tog_s;
    logic [2:0]  er_tog_s;
    logic        next_rx_done;
    logic        next_tx_done;
    logic        next_er_seen;

    // Link domain, all on the reference clock.
    logic        rst_meta;
    logic        rst_link;
    logic        spd_meta;
    logic        spd_link;
    logic        car_meta;
    logic        car_sync;
    logic        car_prev;
    logic [1:0]  rxd;
    logic        rx_er;
    logic        rx_tog;
    logic        er_tog;
    logic        tx_tog;
    rpd_pkg::rpd_tx_state_t tx_state;
    logic [`RPD_DIV_W-1:0]  div;
    logic        ltx_en;
    logic [1:0]  ltx_pair;
    logic        ltx_strobe;

    logic [1:0]  next_rxd;
    logic        next_rx_er;
    logic        next_rx_tog;
    logic        next_er_tog;
    logic        next_tx_tog;
    rpd_pkg::rpd_tx_state_t next_tx_state;
    logic [`RPD_DIV_W-1:0]  next_div;
    logic        next_ltx_en;
    logic [1:0]  next_ltx_pair;
    logic        next_ltx_strobe;
    logic        take;

    always_comb begin
        next_rx_done = rx_tog_s[2] ^ rx_tog_s[1];
        next_tx_done = tx_tog_s[2] ^ tx_tog_s[1];
        next_er_seen = er_tog_s[2] ^ er_tog_s[1];
    end

    always_ff @(posedge CLOCK_I) begin
        if (SRST_I) begin
            speed_q         <= 1'b0;
            rx_tog_s        <= 3'h0;
            tx_tog_s        <= 3'h0;
            er_tog_s        <= 3'h0;
            RX_FRAME_DONE_O <= 1'b0;
            TX_FRAME_DONE_O <= 1'b0;
            RX_ERROR_SEEN_O <= 1'b0;
        end else begin
            speed_q         <= SPEED_100_I;
            rx_tog_s        <= {rx_tog_s[1:0], rx_tog};
            tx_tog_s        <= {tx_tog_s[1:0], tx_tog};
            er_tog_s        <= {er_tog_s[1:0], er_tog};
            RX_FRAME_DONE_O <= next_rx_done;
            TX_FRAME_DONE_O <= next_tx_done;
            RX_ERROR_SEEN_O <= next_er_seen;
        end
    end

    // The raw carrier lifts the output at once; only the synchronised copy
    // can hold it, so the fall lands on a reference clock edge unless carrier drops before car_sync rises.
    assign CRS_DV_O = LINE_CARRIER_I | car_sync;
    assign RXD_O            = rxd;
    assign RX_ER_O          = rx_er;
    assign LINE_TX_EN_O     = ltx_en;
    assign LINE_TX_PAIR_O   = ltx_pair;
    assign LINE_TX_STROBE_O = ltx_strobe;

    always_comb begin
        next_rxd    = `RPD_IDLE_PAIR;
        next_rx_er  = 1'b0;
        next_rx_tog = rx_tog;
        next_er_tog = er_tog;
        // Recovered pairs pass only once carrier is held and decoding
        // is locked; otherwise the idle pair is driven.
        if (car_sync && LINE_RX_LOCK_I) begin
            next_rxd   = LINE_RX_PAIR_I;
            next_rx_er = LINE_RX_CODE_ERR_I;
        end
        if (car_prev && !car_sync) begin
            next_rx_tog = ~rx_tog;
        end
        if (next_rx_er && !rx_er) begin
            next_er_tog = ~er_tog;
        end
    end

    always_comb begin
        next_tx_state   = tx_state;
        next_div        = div;
        next_tx_tog     = tx_tog;
        next_ltx_en     = 1'b0;
        next_ltx_pair   = `RPD_IDLE_PAIR;
        next_ltx_strobe = 1'b0;
        take            = 1'b0;
        // At 10 Mb/s each pair is repeated ten times; one copy is taken.
        case (tx_state)
            rpd_pkg::RPD_TX_IDLE: begin
                next_div = `RPD_DIV_ZERO;
                if (TX_EN_I) begin
                    take          = 1'b1;
                    next_tx_state = rpd_pkg::RPD_TX_FRAME;
                    next_div      = spd_link ? `RPD_DIV_ZERO : 4'h1;
                end
            end
            rpd_pkg::RPD_TX_FRAME: begin
                if (!TX_EN_I) begin
                    // A frame simply ends; no test pulse follows it.
                    next_tx_state = rpd_pkg::RPD_TX_IDLE;
                    next_tx_tog   = ~tx_tog;
                    next_div      = `RPD_DIV_ZERO;
                end else if (spd_link) begin
                    take     = 1'b1;
                    next_div = `RPD_DIV_ZERO;
                end else begin
                    take     = (div == `RPD_DIV_ZERO);
                    next_div = (div == `RPD_DIV_LAST) ? `RPD_DIV_ZERO
                                                     : div + 4'h1;
                end
            end
            default: begin
                next_tx_state = rpd_pkg::RPD_TX_IDLE;
                next_div      = `RPD_DIV_ZERO;
            end
        endcase
        next_ltx_en = TX_EN_I;
        if (TX_EN_I) begin
            next_ltx_pair = take ? TXD_I : ltx_pair;
        end else begin
            next_ltx_pair = `RPD_IDLE_PAIR;
        end
        next_ltx_strobe = take;
    end

    // Every link flop samples and launches on the rising reference edge.
    always_ff @(posedge REF_CLK_I) begin
        rst_meta <= SRST_I;
        rst_link <= rst_meta;
        spd_meta <= speed_q;
        spd_link <= spd_meta;
        car_meta <= LINE_CARRIER_I;
        car_sync <= car_meta;
        if (rst_link) begin
            car_prev   <= 1'b0;
            rxd        <= `RPD_IDLE_PAIR;
            rx_er      <= 1'b0;
            rx_tog     <= 1'b0;
            er_tog     <= 1'b0;
            tx_tog     <= 1'b0;
            tx_state   <= rpd_pkg::RPD_TX_IDLE;
            div        <= `RPD_DIV_ZERO;
            ltx_en     <= 1'b0;
            ltx_pair   <= `RPD_IDLE_PAIR;
            ltx_strobe <= 1'b0;
        end else begin
            car_prev   <= car_sync;
            rxd        <= next_rxd;
            rx_er      <= next_rx_er;
            rx_tog     <= next_rx_tog;
            er_tog     <= next_er_tog;
            tx_tog     <= next_tx_tog;
            tx_state   <= next_tx_state;
            div        <= next_div;
            ltx_en     <= next_ltx_en;
            ltx_pair   <= next_ltx_pair;
            ltx_strobe <= next_ltx_strobe;
        end
    end
endmodule

// ===== dv/rpd_props.sv
`timescale 1ns/100ps
module rpd_props (
    input logic       REF_CLK_I,
    input logic       SRST_I,
    input logic       CRS_DV_O,
    input logic [1:0] RXD_O,
    input logic       RX_ER_O,
    input logic       TX_EN_I,
    input logic [1:0] TXD_I,
    input logic       LINE_CARRIER_I,
    input logic       LINE_RX_LOCK_I,
    input logic       LINE_RX_CODE_ERR_I,
    input logic       LINE_TX_EN_O,
    input logic [1:0] LINE_TX_PAIR_O,
    input logic       LINE_TX_STROBE_O
);
    default clocking @(posedge REF_CLK_I); endclocking
    default disable iff (SRST_I);
    crs_rise_a: assert property (LINE_CARRIER_I |-> CRS_DV_O)
        else $error("valid low with carrier");
    crs_fall_a: assert property
        ($fell(LINE_CARRIER_I) |-> CRS_DV_O ##[1:3] !CRS_DV_O)
        else $error("valid fall wrong");
    idle_rxd_a: assert property (!CRS_DV_O [*2] |-> RXD_O == 2'h0)
        else $error("pair not idle");
    no_lock_a: assert property
        (!$past(LINE_RX_LOCK_I) |-> RXD_O == 2'h0 && !RX_ER_O)
        else $error("pair before lock");
    rx_err_a: assert property
        ($rose(RX_ER_O) |-> $past(LINE_RX_CODE_ERR_I))
        else $error("error without cause");
    tx_en_a: assert property (LINE_TX_EN_O == $past(TX_EN_I))
        else $error("enable copy wrong");
    tx_first_a: assert property
        (TX_EN_I && !$past(TX_EN_I) |=> LINE_TX_STROBE_O
            && LINE_TX_PAIR_O == $past(TXD_I))
        else $error("first pair not taken");
    tx_idle_a: assert property
        (!LINE_TX_EN_O |-> !LINE_TX_STROBE_O && LINE_TX_PAIR_O == 2'h0)
        else $error("idle pair taken");
    cover property ($fell(LINE_CARRIER_I));
    cover property ($rose(RX_ER_O));
    cover property ($fell(TX_EN_I));
endmodule
bind rpd_data_port rpd_props u_props (.*);

// ===== dv/rpd_mac_model.sv
`timescale 1ns/100ps
module rpd_mac_model (
    output logic       ref_clk_o,
    output logic       tx_en_o,
    output logic [1:0] txd_o,
    input  logic       crs_dv_i,
    output logic       col_o
);
    initial begin
        ref_clk_o = 1'b0;
        tx_en_o = 1'b0;
        // The unused upper data and error pins are not modelled; low.
        txd_o = 2'h0;
        #13;
        forever #62.5 ref_clk_o = ~ref_clk_o;
    end
    assign col_o = tx_en_o & crs_dv_i;
    // At 10 Mb/s each pair is held for rep cycles, most significant first.
    task automatic send(input logic [7:0] b, input int rep,
                        input logic [1:0] junk);
        for (int i = 3; i >= 0; i--) begin
            repeat (rep) @(posedge ref_clk_o);
            tx_en_o <= 1'b1;
            txd_o <= b[2*i+:2];
        end
        repeat (rep) @(posedge ref_clk_o);
        tx_en_o <= 1'b0;
        // A nonzero idle pair is left on purpose so it must be ignored.
        txd_o <= junk;
    endtask
endmodule

// ===== dv/test_rmii_phy_data_port.sv
`timescale 1ns/100ps
module test_rmii_phy_data_port;
    logic       CLOCK_I = 1'b0;
    logic       SRST_I = 1'b1;
    logic       SPEED_100_I = 1'b1;
    logic       LINE_CARRIER_I = 1'b0;
    logic       LINE_RX_LOCK_I = 1'b0;
    logic [1:0] LINE_RX_PAIR_I = 2'h0;
    logic       LINE_RX_CODE_ERR_I = 1'b0;
    logic       REF_CLK_I, TX_EN_I, CRS_DV_O, RX_ER_O, LINE_TX_EN_O;
    logic       RX_FRAME_DONE_O, RX_ERROR_SEEN_O, TX_FRAME_DONE_O;
    logic       LINE_TX_STROBE_O;
    logic [1:0] TXD_I, RXD_O, LINE_TX_PAIR_O;
    logic [1:0] txq[$];
    int         fails = 0, check_count = 0, base;
    int         rx_cnt = 0, err_cnt = 0, tx_cnt = 0, mac_err = 0;
    always #50 CLOCK_I = ~CLOCK_I;
    rpd_data_port uut (.*);
    rpd_mac_model mac (.ref_clk_o(REF_CLK_I), .tx_en_o(TX_EN_I),
        .txd_o(TXD_I), .crs_dv_i(CRS_DV_O), .col_o());
    always @(negedge REF_CLK_I)
        if (LINE_TX_STROBE_O === 1'b1) txq.push_back(LINE_TX_PAIR_O);
    // The receiving side only counts errors that come with valid carrier.
    always @(posedge REF_CLK_I)
        if (CRS_DV_O === 1'b1 && RX_ER_O === 1'b1) mac_err++;
    always @(posedge CLOCK_I) begin
        rx_cnt <= rx_cnt + (RX_FRAME_DONE_O === 1'b1);
        err_cnt <= err_cnt + (RX_ERROR_SEEN_O === 1'b1);
        tx_cnt <= tx_cnt + (TX_FRAME_DONE_O === 1'b1);
    end
    task automatic chk(input logic [1:0] got, input logic [1:0] exp);
        check_count++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("Mismatches %0d, checks %0d", fails, check_count);
        if (fails == 0 && check_count > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic wcnt(ref int c, input int e);
        for (int i = 0; i < 40 && c != e; i++) @(negedge CLOCK_I);
        chk(2'(c - e), 2'h0);
        if (c != e) conclude;
    endtask
    task automatic t_tx(input logic spd, input int rep);
        @(posedge CLOCK_I) SPEED_100_I <= spd;
        repeat (8) @(posedge REF_CLK_I);
        txq = {};
        base = tx_cnt + 1;
        mac.send(8'hB4, rep, 2'h3);
        wcnt(tx_cnt, base);
        chk(2'(txq.size() == 4), 2'h1);
        for (int i = 0; i < 4; i++)
            chk(txq[i], 2'(8'hB4 >> (6 - 2 * i)));
    endtask
    task automatic t_rx(input logic err);
        logic [1:0] p[6];
        int         rb;
        p = '{2'h1, 2'h3, 2'h2, 2'h0, 2'h3, 2'h1};
        rb = rx_cnt + 1;
        base = err_cnt + err;
        @(posedge REF_CLK_I) LINE_RX_PAIR_I <= 2'h3;
        @(posedge CLOCK_I) LINE_CARRIER_I <= 1'b1;
        #1 chk(CRS_DV_O, 1'b1);
        repeat (4) @(negedge REF_CLK_I) chk(RXD_O, 2'h0);
        for (int i = 0; i < 7; i++) begin
            @(posedge REF_CLK_I);
            LINE_RX_LOCK_I <= 1'b1;
            LINE_RX_CODE_ERR_I <= err && i == 2;
            if (i < 6) LINE_RX_PAIR_I <= p[i];
            @(negedge REF_CLK_I);
            if (i > 0) chk(RXD_O, p[i-1]);
            chk(RX_ER_O, err && i == 3);
        end
        @(posedge CLOCK_I) LINE_CARRIER_I <= 1'b0;
        #1 chk(CRS_DV_O, 1'b1);
        for (int i = 0; i < 4 && CRS_DV_O; i++) @(negedge REF_CLK_I);
        chk(CRS_DV_O, 1'b0);
        @(negedge REF_CLK_I) chk(RXD_O, 2'h0);
        // Lock is dropped only after valid and the pair have gone idle, so the next frame starts unlocked.
        @(posedge REF_CLK_I) LINE_RX_LOCK_I <= 1'b0;
        wcnt(rx_cnt, rb);
        wcnt(err_cnt, base);
        chk(2'(mac_err), 2'(err));
    endtask
    initial begin
        repeat (6) @(posedge CLOCK_I);
        SRST_I <= 1'b0;
        repeat (8) @(posedge CLOCK_I);
        t_tx(1'b1, 1);
        t_tx(1'b0, 10);
        t_rx(1'b0);
        t_rx(1'b1);
        conclude;
    end
endmodule
